// >>> design/fao_pkg.sv
// Shared constants for the flash converter output pipeline
package fao_pkg;

  // Data path widths
  localparam int CODE_W     = 8;      // Output code width
  localparam int THERMO_W   = 255;    // Comparator thresholds
  localparam int LOW_W      = 7;      // Lower bits under one control

  // Output buffer shape
  localparam int FIFO_DEPTH = 8;      // Words held downstream

  // Strobe edges before output data counts as valid
  localparam logic [1:0] FILL_REGISTERED  = 2'h3; // Board register fitted
  localparam logic [1:0] FILL_TRANSPARENT = 2'h2; // Latch held open

  // Values after reset
  localparam logic       INVERT_N_RESET = 1'h1;   // Pull-up level
  localparam logic       STROBE_RESET   = 1'h0;   // Strobe seen low
  localparam logic [7:0] CODE_RESET     = 8'h00;  // Pipeline contents
  localparam logic [1:0] FILL_RESET     = 2'h0;   // No edges yet

endpackage

// >>> design/fao_fifo_if.sv
`timescale 1ns/1ps
// Valid/ready carrier between the pipeline and its output buffer
interface fao_fifo_if #(
  parameter int W = 8
);
  logic         inValid;  // Filling side offers a word
  logic         inReady;  // Buffer can take a word
  logic [W-1:0] inData;   // Word offered
  logic         outValid; // Buffer holds a word
  logic         outReady; // Drain side takes the word
  logic [W-1:0] outData;  // Oldest word

  // Buffer end
  modport buffer (
    input  inValid, inData, outReady,
    output inReady, outValid, outData
  );

  // Pipeline end
  modport user (
    output inValid, inData, outReady,
    input  inReady, outValid, outData
  );
endinterface

// >>> design/fao_fifo.sv
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides
module fao_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Buffer ports
  fao_fifo_if.buffer port
);
  localparam int AW = $clog2(DEPTH);

  // Whole module state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Storage words
    logic [AW:0]             wr;  // Write pointer, wrap bit on top
    logic [AW:0]             rd;  // Read pointer, wrap bit on top
  } fao_fifo_state_type;

  fao_fifo_state_type s_q;
  fao_fifo_state_type s_d;
  logic               isEmpty;  // Pointers equal
  logic               isFull;   // Same index, other wrap

  // Honest flags from the pointers
  assign isEmpty       = (s_q.wr == s_q.rd);
  assign isFull        = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) &&
                         (s_q.wr[AW] != s_q.rd[AW]);
  assign port.inReady  = !isFull;
  assign port.outValid = !isEmpty;
  assign port.outData  = s_q.mem[s_q.rd[AW-1:0]];

  // Next state
  always_comb begin
    s_d = s_q;
    if (port.inValid && !isFull) begin
      s_d.mem[s_q.wr[AW-1:0]] = port.inData;
      s_d.wr                  = s_q.wr + (AW+1)'(1'h1);
    end
    if (port.outReady && !isEmpty) begin
      s_d.rd = s_q.rd + (AW+1)'(1'h1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> design/fao_pipeline.sv
`timescale 1ns/1ps
// Function
// - Encode 255 comparators to 8-bit code
// - Only the convert strobe sequences sampling
// - Strobe rise freezes comparators, stores code
// - Stored code reaches outputs next edge
// - Board register adds one more edge
// - Build option: transparent latch, no delay
// - High-bit control low inverts top bit
// - Low-bits control low inverts seven bits
// - Controls default high, no inversion
// - Four formats from two controls
module fao_pipeline #(
  parameter bit TransparentOut = 1'h0  // Latch build, no board delay
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  // Converter pins
  input  wire logic                            convert_strobe,
  input  wire logic [fao_pkg::THERMO_W-1:0]    comparatorState,
  input  wire logic                            high_bit_invert_n,
  input  wire logic                            low_bits_invert_n,
  // Board data pins
  output logic      [fao_pkg::CODE_W-1:0]      boardData,
  output logic                                 dataValid,
  // Buffered sample stream
  output logic                                 sampleValid,
  input  wire logic                            sampleReady,
  output logic      [fao_pkg::CODE_W-1:0]      sampleData,
  output logic                                 captureReady,
  output logic                                 sampleDropped
);
  localparam int CW = fao_pkg::CODE_W;
  localparam int TW = fao_pkg::THERMO_W;
  localparam logic [1:0] FILL = TransparentOut ?
    fao_pkg::FILL_TRANSPARENT : fao_pkg::FILL_REGISTERED;

  // Whole module state
  typedef struct packed {
    logic [2:0]    strobeSync;  // Strobe pin stages
    logic          strobeLvl;   // Agreed strobe level
    logic [2:0]    hiSync;      // High-bit control stages
    logic          hiLvl;       // Agreed high-bit control
    logic [2:0]    loSync;      // Low-bits control stages
    logic          loLvl;       // Agreed low-bits control
    logic [TW-1:0] cmpS1;       // Comparator stage one
    logic [TW-1:0] cmpS2;       // Comparator stage two
    logic [TW-1:0] cmpS3;       // Comparator stage three
    logic [TW-1:0] cmpLvl;      // Agreed comparator states
    logic [CW-1:0] heldCode;    // Code frozen at strobe rise
    logic [CW-1:0] convCode;    // Converter output code
    logic [CW-1:0] boardCode;   // Board output register
    logic [1:0]    fillCnt;     // Strobe edges seen, saturating
    logic          pushPend;    // New board word to buffer
    logic          drop;        // Word lost to full buffer
  } fao_state_type;

  fao_state_type s_q;
  fao_state_type s_d;
  logic          strobeRise;    // Agreed strobe rising edge
  logic [CW-1:0] invMask;       // Format inversion mask
  logic [CW-1:0] pinCode;       // Code on the board pins

  // Output buffer link
  fao_fifo_if #(.W(CW)) fifoLink ();

  // Thermometer to binary: number of tripped comparators
  function automatic logic [CW-1:0] encode(input logic [TW-1:0] t);
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < TW; i++) begin
      n = n + CW'(t[i]);
    end
    return n;
  endfunction

  // Rise once stages two and three agree high
  assign strobeRise = (s_q.strobeSync[1] == s_q.strobeSync[2]) &&
                      s_q.strobeSync[2] && !s_q.strobeLvl;

  // Active-low controls set the mask bits
  assign invMask = {~s_q.hiLvl,
                    {fao_pkg::LOW_W{~s_q.loLvl}}};

  // Board pins from register or from open latch
  assign pinCode = TransparentOut ? s_q.convCode
                                  : s_q.boardCode;

  // Next state
  always_comb begin
    s_d = s_q;
    // Three-stage pin synchronisers
    s_d.strobeSync = {s_q.strobeSync[1:0], convert_strobe};
    s_d.hiSync     = {s_q.hiSync[1:0], high_bit_invert_n};
    s_d.loSync     = {s_q.loSync[1:0], low_bits_invert_n};
    s_d.cmpS1      = comparatorState;
    s_d.cmpS2      = s_q.cmpS1;
    s_d.cmpS3      = s_q.cmpS2;
    // Levels follow only when stages two and three agree
    if (s_q.strobeSync[1] == s_q.strobeSync[2]) begin
      s_d.strobeLvl = s_q.strobeSync[2];
    end
    if (s_q.hiSync[1] == s_q.hiSync[2]) begin
      s_d.hiLvl = s_q.hiSync[2];
    end
    if (s_q.loSync[1] == s_q.loSync[2]) begin
      s_d.loLvl = s_q.loSync[2];
    end
    s_d.cmpLvl = (s_q.cmpS2 & s_q.cmpS3) |
                 (s_q.cmpLvl & (s_q.cmpS2 ^ s_q.cmpS3));
    // Pipeline moves only on a strobe rise
    s_d.pushPend = strobeRise;
    if (strobeRise) begin
      s_d.heldCode  = encode(s_q.cmpLvl);
      s_d.convCode  = s_q.heldCode ^ invMask;
      s_d.boardCode = s_q.convCode;
      if (s_q.fillCnt != FILL) begin
        s_d.fillCnt = s_q.fillCnt + 2'h1;
      end
    end
    // Word lost when the buffer cannot take it
    s_d.drop = fifoLink.inValid && !fifoLink.inReady;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q            <= '0;
      s_q.strobeSync <= {3{fao_pkg::STROBE_RESET}};
      s_q.strobeLvl  <= fao_pkg::STROBE_RESET;
      s_q.hiSync     <= {3{fao_pkg::INVERT_N_RESET}};
      s_q.hiLvl      <= fao_pkg::INVERT_N_RESET;
      s_q.loSync     <= {3{fao_pkg::INVERT_N_RESET}};
      s_q.loLvl      <= fao_pkg::INVERT_N_RESET;
      s_q.heldCode   <= fao_pkg::CODE_RESET;
      s_q.convCode   <= fao_pkg::CODE_RESET;
      s_q.boardCode  <= fao_pkg::CODE_RESET;
      s_q.fillCnt    <= fao_pkg::FILL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Buffer links: fill with valid words only, drain on sampleReady
  assign fifoLink.inValid  = s_q.pushPend && (s_q.fillCnt == FILL);
  assign fifoLink.inData   = pinCode;
  assign fifoLink.outReady = sampleReady;

  // Output buffer
  fao_fifo #(
    .W     (CW),
    .DEPTH (fao_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .port  (fifoLink.buffer)
  );

  // Ports
  assign boardData     = pinCode;
  assign dataValid     = (s_q.fillCnt == FILL);
  assign sampleValid   = fifoLink.outValid;
  assign sampleData    = fifoLink.outData;
  assign captureReady  = fifoLink.inReady;
  assign sampleDropped = s_q.drop;

  // Checks
  property p_encode;
    @(posedge clk) disable iff (!rst_b)
    strobeRise |=> s_q.heldCode == encode($past(s_q.cmpLvl));
  endproperty
  a_encode: assert property (p_encode)
    else $error("held code is not the comparator count");

  property p_only_strobe;
    @(posedge clk) disable iff (!rst_b)
    !strobeRise |=> $stable(s_q.heldCode) && $stable(s_q.convCode);
  endproperty
  a_only_strobe: assert property (p_only_strobe)
    else $error("pipeline moved without a strobe rise");

  property p_convert_strobe_latency;
    @(posedge clk) disable iff (!rst_b)
    strobeRise |=> s_q.convCode == ($past(s_q.heldCode) ^ $past(invMask));
  endproperty
  a_convert_strobe_latency: assert property (p_convert_strobe_latency)
    else $error("converter output is not the prior held code");

  property p_board_latency;
    @(posedge clk) disable iff (!rst_b)
    strobeRise |=> s_q.boardCode == $past(s_q.convCode);
  endproperty
  a_board_latency: assert property (p_board_latency)
    else $error("board register missed the converter code");

  property p_pins_change;
    @(posedge clk) disable iff (!rst_b)
    $changed(boardData) |-> $past(strobeRise);
  endproperty
  a_pins_change: assert property (p_pins_change)
    else $error("board pins changed without a strobe rise");

  property p_top_invert;
    @(posedge clk) disable iff (!rst_b)
    strobeRise && !s_q.hiLvl |=>
      s_q.convCode[CW-1] != $past(s_q.heldCode[CW-1]);
  endproperty
  a_top_invert: assert property (p_top_invert)
    else $error("top bit not inverted");

  property p_low_invert;
    @(posedge clk) disable iff (!rst_b)
    strobeRise && !s_q.loLvl |=>
      s_q.convCode[CW-2:0] == ~$past(s_q.heldCode[CW-2:0]);
  endproperty
  a_low_invert: assert property (p_low_invert)
    else $error("lower bits not inverted");

  property p_pullup_default;
    @(posedge clk) rst_b && !$past(rst_b) |-> s_q.hiLvl && s_q.loLvl;
  endproperty
  a_pullup_default: assert property (p_pullup_default)
    else $error("controls not high after reset");

  property p_fill;
    @(posedge clk) disable iff (!rst_b)
    fifoLink.inValid |-> dataValid && $past(strobeRise);
  endproperty
  a_fill: assert property (p_fill)
    else $error("word pushed before pipeline filled");

  // A recognised rise lasts exactly one clock
  property p_rise_pulse;
    @(posedge clk) disable iff (!rst_b)
    strobeRise |=> !strobeRise;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse)
    else $error("strobe rise lasted more than one clock");

  // Agreed strobe level climbs only on a recognised rise
  property p_level_rise;
    @(posedge clk) disable iff (!rst_b)
    $rose(s_q.strobeLvl) |-> $past(strobeRise);
  endproperty
  a_level_rise: assert property (p_level_rise)
    else $error("strobe level rose without a rise");

  // Top bit passes straight while its control is high
  property p_top_keep;
    @(posedge clk) disable iff (!rst_b)
    strobeRise && s_q.hiLvl |=>
      s_q.convCode[CW-1] == $past(s_q.heldCode[CW-1]);
  endproperty
  a_top_keep: assert property (p_top_keep)
    else $error("top bit inverted with control high");

  // Lower bits pass straight while their control is high
  property p_low_keep;
    @(posedge clk) disable iff (!rst_b)
    strobeRise && s_q.loLvl |=>
      s_q.convCode[CW-2:0] == $past(s_q.heldCode[CW-2:0]);
  endproperty
  a_low_keep: assert property (p_low_keep)
    else $error("lower bits inverted with control high");

  // Two's complement format: only the top bit flips
  property p_twos;
    @(posedge clk) disable iff (!rst_b)
    strobeRise && !s_q.hiLvl && s_q.loLvl |=>
      s_q.convCode == {~$past(s_q.heldCode[CW-1]),
                       $past(s_q.heldCode[CW-2:0])};
  endproperty
  a_twos: assert property (p_twos)
    else $error("two's complement format wrong");

  // Once filled the pipeline stays valid until reset
  property p_valid_hold;
    @(posedge clk) disable iff (!rst_b)
    dataValid |=> dataValid;
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("valid dropped after fill");

  // Each rise before fill advances the count by one
  property p_fill_step;
    @(posedge clk) disable iff (!rst_b)
    strobeRise && !dataValid |=>
      s_q.fillCnt == $past(s_q.fillCnt) + 2'h1;
  endproperty
  a_fill_step: assert property (p_fill_step)
    else $error("fill count did not step on a rise");

  // Push into a full buffer shows a drop pulse next clock
  property p_drop;
    @(posedge clk) disable iff (!rst_b)
    fifoLink.inValid && !fifoLink.inReady |=> sampleDropped;
  endproperty
  a_drop: assert property (p_drop)
    else $error("lost word not flagged");

  // Main scenarios
  c_rise: cover property (@(posedge clk) disable iff (!rst_b) strobeRise);
  c_push: cover property (@(posedge clk) disable iff (!rst_b)
    fifoLink.inValid && fifoLink.inReady);
  c_drop: cover property (@(posedge clk) disable iff (!rst_b) s_q.drop);
  c_twos: cover property (@(posedge clk) disable iff (!rst_b)
    strobeRise && !s_q.hiLvl && s_q.loLvl);
endmodule

// >>> tb/fao_capture_model.sv
`timescale 1ns/1ps
// Downstream capture logic: takes words, may stall or pace itself
module fao_capture_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Pacing from the bench
  input  wire logic        holdOff,
  input  wire logic        slow,
  // Sample stream
  input  wire logic        sampleValid,
  output logic             sampleReady,
  input  wire logic [7:0]  sampleData
);
  logic [7:0] got[$];  // Words taken, oldest first
  logic       pace;    // Toggles every falling edge, paces ready in slow mode

  // Ready settles low before any clock
  initial begin
    sampleReady = 1'b0;
    pace = 1'b0;
  end

  // Ready changes only after the falling edge
  always @(negedge clk) begin
    pace <= ~pace;
    sampleReady <= rst_b && !holdOff && (!slow || pace);
  end

  // Takes a word where both sides agree
  always @(posedge clk) begin
    if (sampleValid === 1'b1 && sampleReady === 1'b1) begin
      got.push_back(sampleData);
    end
  end
endmodule

// >>> tb/fao_pipeline_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the converter output pipeline
module fao_pipeline_tb_top;
  logic         clk;                // Bench clock
  logic         rst_b;              // Reset, active low
  logic         convert_strobe;     // Strobe pin
  logic [254:0] comparatorState;    // Thermometer input
  logic         high_bit_invert_n;  // Top bit control
  logic         low_bits_invert_n;  // Low bits control
  logic [7:0]   boardData;          // Registered build pins
  logic         dataValid;          // Registered build filled
  logic [7:0]   latData;            // Latch build pins
  logic         latValid;           // Latch build filled
  logic         sampleValid;        // Stream word present
  logic         sampleReady;        // Stream word taken
  logic [7:0]   sampleData;         // Stream word
  logic         captureReady;       // Buffer has room
  logic         sampleDropped;      // Word lost
  logic         stall;              // Far side holds off
  logic         slow;               // Far side paces
  logic [7:0]   heldExp;            // Model of stored code
  logic [7:0]   convExp;            // Model of converter pins
  logic [7:0]   boardExp;           // Model of board pins
  logic [7:0]   expQ[$];            // Expected stream
  int           riseCnt;            // Strobe rises so far
  int           dropCnt;            // Drop pulses seen
  int           numErrors;          // Mismatches
  int           cmpCount;           // Comparisons

  // Registered build under test
  fao_pipeline dut (.clk(clk), .rst_b(rst_b),
    .convert_strobe(convert_strobe), .comparatorState(comparatorState),
    .high_bit_invert_n(high_bit_invert_n),
    .low_bits_invert_n(low_bits_invert_n), .boardData(boardData),
    .dataValid(dataValid), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData),
    .captureReady(captureReady), .sampleDropped(sampleDropped));

  // Latch build, stream always drained
  fao_pipeline #(.TransparentOut(1'b1)) dutLatch (.clk(clk),
    .rst_b(rst_b), .convert_strobe(convert_strobe),
    .comparatorState(comparatorState),
    .high_bit_invert_n(high_bit_invert_n),
    .low_bits_invert_n(low_bits_invert_n), .boardData(latData),
    .dataValid(latValid), .sampleValid(), .sampleReady(1'b1),
    .sampleData(), .captureReady(), .sampleDropped());

  // Downstream partner
  fao_capture_model capture (.clk(clk), .rst_b(rst_b), .holdOff(stall),
    .slow(slow), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sampleData(sampleData));

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts drop pulses
  always @(posedge clk) begin
    if (sampleDropped === 1'b1) dropCnt++;
  end

  // Single compare with report
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: %s %h/%h", $time, msg, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic reportAndStop();
    $display("comparisons %0d errors %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Thermometer with n ones
  function automatic logic [254:0] thermo(input int n);
    thermo = '0;
    for (int i = 0; i < n; i++) thermo[i] = 1'b1;
  endfunction

  // One strobe period, then pins against the model
  task automatic strobe_cycle(input int n);
    logic [7:0] mask;
    mask = {~high_bit_invert_n, {7{~low_bits_invert_n}}};
    comparatorState = thermo(n);
    convert_strobe = 1'b0;
    repeat (5) @(negedge clk);
    convert_strobe = 1'b1;
    repeat (5) @(negedge clk);
    boardExp = convExp;
    convExp = heldExp ^ mask;
    heldExp = 8'(n);
    riseCnt++;
    if (riseCnt >= 3) expQ.push_back(boardExp);
    check(boardData, boardExp, "board code");
    check(latData, convExp, "latch code");
    check({7'h00, dataValid}, {7'h00, riseCnt >= 3}, "valid");
    check({7'h00, latValid}, {7'h00, riseCnt >= 2}, "lvalid");
  endtask

  // Waits for an empty stream, then words in order
  task automatic drain_and_compare();
    int i;
    i = 0;
    while (sampleValid !== 1'b0 && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (i >= 100) begin
      numErrors++;
      $display("wrong value at %0t: stream never drained", $time);
    end
    check(8'(capture.got.size()), 8'(expQ.size()), "count");
    foreach (expQ[k]) begin
      if (k < capture.got.size()) begin
        check(capture.got[k], expQ[k], "word");
      end
    end
    capture.got.delete();
    expQ.delete();
  endtask

  // Fill from reset, extreme codes
  task automatic test_fill();
    strobe_cycle(0);
    strobe_cycle(255);
    strobe_cycle(128);
    strobe_cycle(1);
    strobe_cycle(254);
    drain_and_compare();
  endtask

  // All four output formats, slow far side
  task automatic test_formats();
    slow = 1'b1;
    for (int f = 0; f < 4; f++) begin
      high_bit_invert_n = f[1];
      low_bits_invert_n = f[0];
      strobe_cycle(f * 60 + 7);
      strobe_cycle(f * 50 + 100);
      strobe_cycle(200 - f);
    end
    high_bit_invert_n = 1'b1;
    low_bits_invert_n = 1'b1;
    strobe_cycle(33);
    strobe_cycle(66);
    slow = 1'b0;
    drain_and_compare();
  endtask

  // Stalled far side: buffer fills, two words lost
  task automatic test_overflow();
    stall = 1'b1;
    dropCnt = 0;
    for (int k = 0; k < 10; k++) strobe_cycle(k * 25);
    @(negedge clk);  // Last drop pulse is counted one edge later
    expQ = expQ[0:7];
    check({7'h00, captureReady}, 8'h00, "full");
    check(8'(dropCnt), 8'h02, "drops");
    check(sampleData, expQ[0], "held word");
    stall = 1'b0;
    drain_and_compare();
    check({7'h00, captureReady}, 8'h01, "room");
  endtask

  // Main sequence
  initial begin
    {rst_b, convert_strobe, comparatorState} = '0;
    {high_bit_invert_n, low_bits_invert_n, stall, slow} = 4'hC;
    {heldExp, convExp, boardExp} = '0;
    {riseCnt, dropCnt, numErrors, cmpCount} = '0;
    repeat (8) @(negedge clk);
    check(boardData, 8'h00, "reset code");
    check({5'h00, dataValid, sampleValid, captureReady}, 8'h01,
          "reset");
    rst_b = 1'b1;
    @(negedge clk);
    test_fill();
    test_formats();
    test_overflow();
    reportAndStop();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    numErrors++;
    reportAndStop();
  end
endmodule
